// [verilog/mgs_pkg.sv]
/*
 * Shared constants and types for the motor gate driver status and
 * configuration register bank: register addresses, field positions,
 * reset values, synchroniser depth and the carrier structs.
 * Assumes a 16-bit serial frame: one read flag, four address bits
 * and eleven data bits, most significant bit first.
 */
package mgs_pkg;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int DATA_W = 11;
    localparam int ADDR_W = 4;
    localparam int RW_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 11;
    localparam int HEAD_BITS = 5;
    localparam int SYNC_STAGES = 3;

    // Register addresses
    localparam logic [3:0] ADDR_WARN = 4'h1;
    localparam logic [3:0] ADDR_OC = 4'h2;
    localparam logic [3:0] ADDR_CHIP = 4'h3;
    localparam logic [3:0] ADDR_GS = 4'h4;
    localparam logic [3:0] ADDR_HS = 4'h5;
    localparam logic [3:0] ADDR_LS = 4'h6;
    localparam logic [3:0] ADDR_TIMING = 4'h7;
    localparam logic [3:0] ADDR_UNUSED = 4'h8;
    localparam logic [3:0] ADDR_OPER = 4'h9;
    localparam logic [3:0] ADDR_SHUNT = 4'ha;
    localparam logic [3:0] ADDR_REGUL = 4'hb;
    localparam logic [3:0] ADDR_DSSENSE = 4'hc;

    // Warning register fields
    localparam int WARN_FAULT = 10;
    localparam int WARN_HEAT_175 = 8;
    localparam int WARN_SUPPLY_LOW = 7;
    localparam int WARN_SUPPLY_HIGH = 6;
    localparam int WARN_LIVE_OR = 5;
    localparam int WARN_PUMP_LOW = 4;
    localparam int WARN_HEAT_105 = 3;
    localparam int WARN_HEAT_125 = 2;
    localparam int WARN_HEAT_135 = 1;
    localparam int WARN_OVERHEAT = 0;

    // Overcurrent register fields
    localparam int OC_DS_LSB = 5;
    localparam int OC_SENSE_LSB = 0;

    // Chip fault register fields
    localparam int CHIP_LOCKOUT2 = 10;
    localparam int CHIP_WATCHDOG = 9;
    localparam int CHIP_SHUTDOWN = 8;
    localparam int CHIP_REG_LOW = 6;
    localparam int CHIP_ANALOG_LOW = 5;
    localparam int CHIP_LOW_GATE = 4;
    localparam int CHIP_PUMP_LOW = 2;
    localparam int CHIP_PUMP_OVER = 1;
    localparam int CHIP_PUMP_ABS = 0;

    // Gate-source register fields
    localparam int GS_LSB = 5;

    // Operation register control bits
    localparam int OPER_DIS_LOCKOUT2 = 9;
    localparam int OPER_DIS_GATE_FLT = 8;
    localparam int OPER_DIS_SENSE = 4;
    localparam int OPER_CLEAR = 1;

    // Reset values
    localparam logic [10:0] RST_STATUS = 11'h000;
    localparam logic [10:0] RST_HS = 11'h344;
    localparam logic [10:0] RST_LS = 11'h344;
    localparam logic [10:0] RST_TIMING = 11'h000;
    localparam logic [10:0] RST_OPER = 11'h000;
    localparam logic [10:0] RST_SHUNT = 11'h000;
    localparam logic [10:0] RST_REGUL = 11'h000;
    localparam logic [10:0] RST_DSSENSE = 11'h000;
    localparam logic CS_IDLE = 1'b1;

    // Monitor outputs from the analog side, one bit per condition
    typedef struct packed {
        logic fault;
        logic heat_step_175;
        logic main_supply_low_warn;
        logic main_supply_high_warn;
        logic charge_pump_low_warn;
        logic heat_step_105;
        logic heat_step_125;
        logic heat_step_135;
        logic overheat_warning;
        logic [5:0] ds_live;
        logic [5:0] ds_fault;
        logic [2:0] sense_overcurrent;
        logic main_supply_lockout2;
        logic watchdog_expired;
        logic overheat_shutdown;
        logic regulator_out_low;
        logic analog_supply_low;
        logic low_gate_supply_fault;
        logic high_pump_low_fault;
        logic high_pump_over_fault;
        logic high_pump_over_abs_fault;
        logic [5:0] gs_fault;
    } mgs_mon_t;

    // Configuration registers as seen by the driver logic
    typedef struct packed {
        logic [10:0] high_side_drive_setup;
        logic [10:0] low_side_drive_setup;
        logic [10:0] drive_timing_setup;
        logic [10:0] chip_operation;
        logic [10:0] shunt_amp_setup;
        logic [10:0] regulator_setup;
        logic [10:0] drain_source_sense_setup;
    } mgs_cfg_t;

    // One received frame
    typedef struct packed {
        logic rd;
        logic [3:0] addr;
        logic [10:0] data;
    } mgs_frame_t;

    typedef logic [15:0][10:0] mgs_bank_t;

    localparam mgs_cfg_t CFG_DEFAULT = '{
        high_side_drive_setup: RST_HS,
        low_side_drive_setup: RST_LS,
        drive_timing_setup: RST_TIMING,
        chip_operation: RST_OPER,
        shunt_amp_setup: RST_SHUNT,
        regulator_setup: RST_REGUL,
        drain_source_sense_setup: RST_DSSENSE
    };

endpackage

// [verilog/mgs_spi_link.sv]
/*
 * Serial clock side of the register bank: shifts the command word in
 * on falling edges, drives the response out on rising edges.
 * Assumes clock low at select edges, and a bank snapshot that stays
 * frozen while select is low.
 */
module mgs_spi_link
    import mgs_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_reset,
    input wire mgs_bank_t i_bank,
    output logic o_sdo,
    output mgs_frame_t o_word,
    output logic o_done_tgl,
    output logic o_over_tgl
);

    logic [4:0] fall_cnt_reg;
    logic [4:0] rise_cnt_reg;
    logic [15:0] shift_reg;
    logic [3:0] addr_reg;
    logic [15:0] word_reg;
    logic done_tgl_reg;
    logic over_tgl_reg;
    logic sdo_reg;
    logic [15:0] resp_word;
    logic [3:0] out_idx;
    logic sdo_next;

    // Capture on falling edges, cleared while deselected or in reset
    always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_reset)
    begin
        if (i_cs_n || i_reset)
        begin
            fall_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            addr_reg <= 4'h0;
        end
        else
        begin
            shift_reg <= {shift_reg[14:0], i_sdi};
            if (fall_cnt_reg != 5'h1f)
                fall_cnt_reg <= fall_cnt_reg + 5'h01;
            if (fall_cnt_reg == 5'h04)
                addr_reg <= {shift_reg[2:0], i_sdi};
        end
    end

    // Frame complete at 16th edge, overrun at the 17th
    always_ff @(negedge i_sclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            word_reg <= 16'h0000;
            done_tgl_reg <= 1'b0;
            over_tgl_reg <= 1'b0;
        end
        else if (!i_cs_n)
        begin
            if (fall_cnt_reg == 5'h0f)
            begin
                word_reg <= {shift_reg[14:0], i_sdi};
                done_tgl_reg <= ~done_tgl_reg; // RULE_13
            end
            if (fall_cnt_reg == 5'h10)
                over_tgl_reg <= ~over_tgl_reg; // RULE_13
        end
    end

    // Response: five zero head bits, then the addressed register
    assign resp_word = {5'h00, i_bank[addr_reg]}; // RULE_14
    assign out_idx = 4'hf - rise_cnt_reg[3:0];
    assign sdo_next = (rise_cnt_reg < 5'h10) ? resp_word[out_idx] : 1'b0;

    // Drive on rising edges
    always_ff @(posedge i_sclk or posedge i_cs_n or posedge i_reset)
    begin
        if (i_cs_n || i_reset)
        begin
            rise_cnt_reg <= 5'h00;
            sdo_reg <= 1'b0;
        end
        else
        begin
            sdo_reg <= sdo_next;
            if (rise_cnt_reg != 5'h1f)
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
        end
    end

    assign o_sdo = sdo_reg;
    assign o_word = mgs_frame_t'(word_reg);
    assign o_done_tgl = done_tgl_reg;
    assign o_over_tgl = over_tgl_reg;

endmodule

// [verilog/mgs_status_regs.sv]
/*
 * Status and configuration register bank of a three-phase gate driver,
 * reached over a 16-bit serial frame on its own serial clock.
 * Assumes monitor outputs and the sleep-entry level arrive
 * asynchronously, and that the serial clock stops between frames.
 */
// Operation
// RULE_01: The four status registers are read-only and show monitor state.
// RULE_02: Register 0x1 holds heat steps in bits 3, 2, 1, 8 and warning in 0.
// RULE_03: Bit 5 of 0x1 is the live unlatched OR of the six drain monitors.
// RULE_04: 0x1 shows supply low in 7, high in 6, fault in 10, 9 reserved.
// RULE_05: Bit 4 of 0x1 shows the high-side charge pump low warning.
// RULE_06: Any access to 0x1 gives the watchdog a kick; host must do so.
// RULE_07: 0x2 bits 10 to 5 hold drain faults per transistor, 4:3 reserved.
// RULE_08: 0x2 bits 0, 1, 2 hold sense overcurrent for channels A, B, C.
// RULE_09: 0x3 shows lockout2 in 10, watchdog in 9, shutdown in 8.
// RULE_10: 0x3 shows regulator low in 6, analog low in 5, low gate in 4.
// RULE_11: 0x3 shows pump low in 2, pump over in 1, pump absolute in 0.
// RULE_12: 0x4 bits 10 to 5 hold gate-source faults, low bits reserved.
// RULE_13: A frame is 16 bits: read flag, four address and eleven data.
// RULE_14: Each frame answers with the addressed register's current value.
// RULE_15: Setup registers reset at power-up and sleep entry only.
// RULE_16: Reserved bits read zero; writes to status or 0x8 do nothing.
// RULE_17: Status bits read zero after power-up until a monitor trips.
module mgs_status_regs
    import mgs_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire mgs_mon_t i_monitors,
    input wire logic i_sleep_entry,
    output logic o_sdo,
    output logic o_sdo_oe,
    output mgs_cfg_t o_config,
    output logic o_watchdog_kick,
    output logic o_clear_faults
);

    localparam int MON_W = $bits(mgs_mon_t);
    localparam int SYNC_W = MON_W + 4;
    localparam logic [SYNC_W-1:0] SYNC_INIT =
        {{(SYNC_W-3){1'b0}}, CS_IDLE, 2'b00};

    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_st;
    mgs_mon_t mon_st;
    logic sleep_st;
    logic cs_st;
    logic done_st;
    logic over_st;
    logic cs_prev_reg;
    logic sleep_prev_reg;
    logic done_seen_reg;
    logic over_seen_reg;
    logic [10:0] warn_reg;
    logic [10:0] oc_reg;
    logic [10:0] chip_reg;
    logic [10:0] gs_reg;
    mgs_cfg_t cfg_reg;
    mgs_bank_t bank_live;
    mgs_bank_t snap_reg;
    mgs_frame_t word;
    logic link_done_tgl;
    logic link_over_tgl;
    logic sdo_oe_reg;
    logic kick_reg;
    logic clear_reg;

    // Serial clock side
    mgs_spi_link u_link (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_sdi(i_sdi),
        .i_reset(i_reset),
        .i_bank(snap_reg),
        .o_sdo(o_sdo),
        .o_word(word),
        .o_done_tgl(link_done_tgl),
        .o_over_tgl(link_over_tgl)
    );

    // Monitors, sleep entry, select and the link toggles pass four flops
    assign sync_raw = {i_monitors, i_sleep_entry, i_cs_n,
        link_done_tgl, link_over_tgl};

    for (genvar g = 0; g < SYNC_W; g++)
    begin : g_sync
        logic [2:0] chain_reg;
        logic stable_reg;
        // Change counts once stages two and three agree
        always_ff @(posedge i_clk_sys)
        begin
            if (i_reset)
            begin
                chain_reg <= {3{SYNC_INIT[g]}};
                stable_reg <= SYNC_INIT[g];
            end
            else
            begin
                chain_reg <= {chain_reg[1:0], sync_raw[g]};
                if (chain_reg[1] == chain_reg[2])
                    stable_reg <= chain_reg[2];
            end
        end
        assign sync_st[g] = stable_reg;
    end

    assign mon_st = mgs_mon_t'(sync_st[SYNC_W-1:4]);
    assign sleep_st = sync_st[3];
    assign cs_st = sync_st[2];
    assign done_st = sync_st[1];
    assign over_st = sync_st[0];

    // Frame events and decode
    logic cs_rise;
    logic sleep_rise;
    logic commit;
    logic wr;
    logic hit_warn;
    logic dis_gate;
    logic dis_sense;
    logic dis_lockout;
    assign cs_rise = cs_st & ~cs_prev_reg;
    assign sleep_rise = sleep_st & ~sleep_prev_reg;
    assign commit = cs_rise & (done_st != done_seen_reg) // RULE_13
        & (over_st == over_seen_reg);
    assign wr = commit & ~word.rd;
    assign hit_warn = commit & (word.addr == ADDR_WARN);
    assign dis_gate = cfg_reg.chip_operation[OPER_DIS_GATE_FLT];
    assign dis_sense = cfg_reg.chip_operation[OPER_DIS_SENSE];
    assign dis_lockout = cfg_reg.chip_operation[OPER_DIS_LOCKOUT2];

    // Edge history and toggle baselines
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            cs_prev_reg <= CS_IDLE;
            sleep_prev_reg <= 1'b0;
            done_seen_reg <= 1'b0;
            over_seen_reg <= 1'b0;
        end
        else
        begin
            cs_prev_reg <= cs_st;
            sleep_prev_reg <= sleep_st;
            if (cs_rise)
            begin
                done_seen_reg <= done_st;
                over_seen_reg <= over_st;
            end
        end
    end

    // Status registers follow the monitors, reserved bits zero
    logic [10:0] warn_next;
    logic [10:0] oc_next;
    logic [10:0] chip_next;
    logic [10:0] gs_next;
    assign warn_next = {mon_st.fault, 1'b0, mon_st.heat_step_175, // RULE_04
        mon_st.main_supply_low_warn, mon_st.main_supply_high_warn,
        |mon_st.ds_live, // RULE_03
        mon_st.charge_pump_low_warn, // RULE_05
        mon_st.heat_step_105, mon_st.heat_step_125, // RULE_02
        mon_st.heat_step_135, mon_st.overheat_warning};
    assign oc_next = {mon_st.ds_fault, 2'b00, // RULE_07
        dis_sense ? 3'b000 : mon_st.sense_overcurrent}; // RULE_08
    assign chip_next = {mon_st.main_supply_lockout2 & ~dis_lockout, // RULE_09
        mon_st.watchdog_expired, mon_st.overheat_shutdown, 1'b0,
        mon_st.regulator_out_low, mon_st.analog_supply_low, // RULE_10
        mon_st.low_gate_supply_fault, 1'b0,
        mon_st.high_pump_low_fault, mon_st.high_pump_over_fault, // RULE_11
        mon_st.high_pump_over_abs_fault};
    assign gs_next = {dis_gate ? 6'h00 : mon_st.gs_fault, 5'h00}; // RULE_12

    // Read-only: no write path reaches these
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            warn_reg <= RST_STATUS; // RULE_17
            oc_reg <= RST_STATUS;
            chip_reg <= RST_STATUS;
            gs_reg <= RST_STATUS;
        end
        else
        begin
            warn_reg <= warn_next; // RULE_01
            oc_reg <= oc_next;
            chip_reg <= chip_next;
            gs_reg <= gs_next;
        end
    end

    // Write strobes per setup register
    logic wr_hs;
    logic wr_ls;
    logic wr_timing;
    logic wr_oper;
    logic wr_shunt;
    logic wr_regul;
    logic wr_dssense;
    assign wr_hs = wr & (word.addr == ADDR_HS);
    assign wr_ls = wr & (word.addr == ADDR_LS);
    assign wr_timing = wr & (word.addr == ADDR_TIMING);
    assign wr_oper = wr & (word.addr == ADDR_OPER);
    assign wr_shunt = wr & (word.addr == ADDR_SHUNT);
    assign wr_regul = wr & (word.addr == ADDR_REGUL);
    assign wr_dssense = wr & (word.addr == ADDR_DSSENSE);

    // Setup registers; clear bit is a command and never stored
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || sleep_rise)
            cfg_reg <= CFG_DEFAULT; // RULE_15
        else if (wr_hs)
            cfg_reg.high_side_drive_setup <= word.data;
        else if (wr_ls)
            cfg_reg.low_side_drive_setup <= word.data;
        else if (wr_timing)
            cfg_reg.drive_timing_setup <= word.data;
        else if (wr_oper)
            cfg_reg.chip_operation <= word.data & ~(11'h001 << OPER_CLEAR);
        else if (wr_shunt)
            cfg_reg.shunt_amp_setup <= word.data;
        else if (wr_regul)
            cfg_reg.regulator_setup <= word.data;
        else if (wr_dssense)
            cfg_reg.drain_source_sense_setup <= word.data; // RULE_16
    end

    // Readable bank; unmapped and reserved slots read zero
    assign bank_live = {11'h000, 11'h000, 11'h000, // RULE_16
        cfg_reg.drain_source_sense_setup, cfg_reg.regulator_setup,
        cfg_reg.shunt_amp_setup, cfg_reg.chip_operation, 11'h000,
        cfg_reg.drive_timing_setup, cfg_reg.low_side_drive_setup,
        cfg_reg.high_side_drive_setup, gs_reg, chip_reg, oc_reg,
        warn_reg, 11'h000};

    // Snapshot frozen while selected, read by the serial side
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            snap_reg <= '0;
        else if (cs_st)
            snap_reg <= bank_live; // RULE_14
    end

    // Output pulses and drive enable
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            sdo_oe_reg <= 1'b0;
            kick_reg <= 1'b0;
            clear_reg <= 1'b0;
        end
        else
        begin
            sdo_oe_reg <= ~cs_st;
            kick_reg <= hit_warn; // RULE_06
            clear_reg <= wr_oper & word.data[OPER_CLEAR];
        end
    end

    assign o_sdo_oe = sdo_oe_reg;
    assign o_config = cfg_reg;
    assign o_watchdog_kick = kick_reg;
    assign o_clear_faults = clear_reg;

    a_kick_on_warn: assert property ( // RULE_06
        @(posedge i_clk_sys) disable iff (i_reset)
        hit_warn |=> o_watchdog_kick ##1 !o_watchdog_kick)
        else $error("watchdog kick missing or stretched");

    a_live_or: assert property ( // RULE_03
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> warn_reg[WARN_LIVE_OR] == $past(|mon_st.ds_live))
        else $error("live drain OR not reported");

    a_cfg_stable: assert property ( // RULE_15
        @(posedge i_clk_sys) disable iff (i_reset)
        !wr && !sleep_rise |=> $stable(o_config))
        else $error("setup register changed without a write");

    a_sleep_default: assert property ( // RULE_15
        @(posedge i_clk_sys) disable iff (i_reset)
        sleep_rise |=> o_config == CFG_DEFAULT)
        else $error("sleep entry did not restore defaults");

    a_reserved_zero: assert property ( // RULE_16
        @(posedge i_clk_sys) disable iff (i_reset)
        warn_reg[9] == 1'b0 && oc_reg[4:3] == 2'b00
        && chip_reg[7] == 1'b0 && chip_reg[3] == 1'b0
        && gs_reg[4:0] == 5'h00 && snap_reg[ADDR_UNUSED] == 11'h000)
        else $error("reserved bit reads nonzero");

    a_reset_zero: assert property ( // RULE_17
        @(posedge i_clk_sys)
        $past(i_reset) && !i_reset |-> warn_reg == RST_STATUS
        && oc_reg == RST_STATUS
        && chip_reg == RST_STATUS && gs_reg == RST_STATUS)
        else $error("status not zero after reset");

    a_deselect_float: assert property ( // RULE_13
        @(posedge i_clk_sys) disable iff (i_reset)
        cs_st [*2] |-> !o_sdo_oe)
        else $error("output driven while deselected");

    a_gate_mask: assert property ( // RULE_12
        @(posedge i_clk_sys) disable iff (i_reset)
        $past(dis_gate) |-> gs_reg == 11'h000)
        else $error("gate-source faults shown while disabled");

    a_clear_pulse: assert property ( // RULE_15
        @(posedge i_clk_sys) disable iff (i_reset)
        o_clear_faults |-> !cfg_reg.chip_operation[OPER_CLEAR]
        ##1 !o_clear_faults)
        else $error("clear command stored or stretched");

endmodule

// [tb/mgs_spi_host.sv]
/*
 * Serial master model for the gate driver register bank: sends one
 * frame of any bit count and returns the eleven response bits of a 16-bit frame.
 * Assumes the bench calls xfer and waits for it to return.
 */
module mgs_spi_host
    import mgs_pkg::*;
(
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo,
    output logic [10:0] o_resp,
    output logic o_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels: clock low, deselected
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        o_resp = '0;
        o_valid = 1'b0;
    end

    // One frame, MSB first, 15 ns serial clock
    task automatic xfer(input logic [15:0] cmd, input int nbits);
        logic [15:0] rx;
        rx = '0;
        o_cs_n = 1'b0;
        #100;
        for (int k = 0; k < nbits; k++)
        begin
            o_sclk = 1'b1;
            o_sdi = (k < 16) ? cmd[15 - k] : 1'b0;
            #7.5;
            o_sclk = 1'b0;
            rx = {rx[14:0], i_sdo};
            #7.5;
        end
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        if (nbits == 16)
        begin
            o_resp = rx[10:0];
            o_valid = 1'b1;
            #1;
            o_valid = 1'b0;
        end
        #600;
    endtask
endmodule

// [tb/mgs_status_regs_tb.sv]
/*
 * Self-checking bench for the status and setup register bank.
 * Assumes the serial master model drives the link; expected answers
 * are queued before each frame and compared as answers arrive.
 */
module mgs_status_regs_tb
    import mgs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk_sys;
    logic i_reset;
    logic i_sclk;
    logic i_cs_n;
    logic i_sdi;
    logic i_sleep_entry;
    mgs_mon_t i_monitors;
    logic o_sdo;
    logic o_sdo_oe;
    mgs_cfg_t o_config;
    logic o_watchdog_kick;
    logic o_clear_faults;
    logic [10:0] resp;
    logic resp_valid;
    logic [10:0] exp_q[$];
    logic [10:0] v5;
    logic [10:0] v;
    int errors;
    int tests_run;
    int kicks;
    int clears;
    int k0;
    int oe_hits;

    mgs_status_regs mgs_status_regs_inst (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_sdi(i_sdi),
        .i_monitors(i_monitors),
        .i_sleep_entry(i_sleep_entry),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe),
        .o_config(o_config),
        .o_watchdog_kick(o_watchdog_kick),
        .o_clear_faults(o_clear_faults)
    );

    mgs_spi_host mgs_spi_host_inst (
        .o_sclk(i_sclk),
        .o_cs_n(i_cs_n),
        .o_sdi(i_sdi),
        .i_sdo(o_sdo),
        .o_resp(resp),
        .o_valid(resp_valid)
    );

    // System clock
    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // Counts of one-cycle pulses and of drive-enable cycles
    always @(posedge i_clk_sys)
    begin
        if (o_watchdog_kick === 1'b1)
            kicks++;
        if (o_clear_faults === 1'b1)
            clears++;
        if (o_sdo_oe === 1'b1)
            oe_hits++;
    end

    task automatic check(input logic [79:0] seen, input logic [79:0] want);
        tests_run++;
        if (seen !== want)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Expected status word for a monitor vector
    function automatic logic [10:0] stat(input mgs_mon_t m,
        input logic [3:0] a);
        case (a)
            4'h1: stat = {m.fault, 1'b0, m.heat_step_175,
                m.main_supply_low_warn, m.main_supply_high_warn,
                |m.ds_live, m.charge_pump_low_warn,
                m.heat_step_105, m.heat_step_125, m.heat_step_135,
                m.overheat_warning};
            4'h2: stat = {m.ds_fault, 2'b00,
                m.sense_overcurrent};
            4'h3: stat = {m.main_supply_lockout2, m.watchdog_expired,
                m.overheat_shutdown, 1'b0, m.regulator_out_low,
                m.analog_supply_low, m.low_gate_supply_fault,
                1'b0, m.high_pump_low_fault, m.high_pump_over_fault,
                m.high_pump_over_abs_fault};
            4'h4: stat = {m.gs_fault, 5'h00};
            4'h5, 4'h6: stat = RST_HS;
            default: stat = 11'h000;
        endcase
    endfunction

    // Queue the answer, then send the frame
    task automatic frame(input logic rd, input logic [3:0] a,
        input logic [10:0] d, input logic [10:0] want);
        exp_q.push_back(want);
        mgs_spi_host_inst.xfer({rd, a, d}, 16);
    endtask

    // Answer watcher
    initial
    begin
        forever
        begin
            @(posedge resp_valid);
            check(resp, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
        end
    end

    // Hang guard
    initial
    begin
        #500000;
        errors++;
        close_out();
    end

    // Main sequence
    initial
    begin
        i_reset = 1'b0;
        #1;
        i_reset = 1'b1;
        i_sleep_entry = 1'b0;
        i_monitors = '0;
        errors = 0;
        tests_run = 0;
        kicks = 0;
        clears = 0;
        oe_hits = 0;
        void'($urandom(32'h71ed3515));
        repeat (5) @(negedge i_clk_sys);
        i_reset = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        check(o_config, CFG_DEFAULT);
        check(o_sdo_oe, 1'b0);
        for (int a = 0; a < 16; a++)
            frame(1'b1, a[3:0], 11'h000, stat('0, a[3:0]));
        check(oe_hits > 400, 1'b1);
        for (int n = 0; n < 6; n++)
        begin
            @(negedge i_clk_sys);
            i_monitors = mgs_mon_t'(39'({$urandom, $urandom}));
            repeat (8) @(negedge i_clk_sys);
            for (int a = 1; a < 5; a++)
                frame(1'b1, a[3:0], 11'h000, stat(i_monitors, a[3:0]));
        end
        for (int a = 1; a < 5; a++)
        begin
            v = stat(i_monitors, a[3:0]);
            frame(1'b0, a[3:0], 11'h7ff, v);
            frame(1'b1, a[3:0], 11'h000, v);
        end
        frame(1'b0, ADDR_UNUSED, 11'h7ff, 11'h000);
        frame(1'b1, ADDR_UNUSED, 11'h000, 11'h000);
        k0 = kicks;
        frame(1'b1, ADDR_WARN, 11'h000, stat(i_monitors, ADDR_WARN));
        check(kicks, k0 + 1);
        frame(1'b0, ADDR_WARN, 11'h000, stat(i_monitors, ADDR_WARN));
        frame(1'b1, ADDR_CHIP, 11'h000, stat(i_monitors, ADDR_CHIP));
        check(kicks, k0 + 2);
        v5 = 11'($urandom) & 11'h3ff;
        frame(1'b0, ADDR_HS, v5, RST_HS);
        frame(1'b1, ADDR_HS, 11'h000, v5);
        check(o_config.high_side_drive_setup, v5);
        v = 11'($urandom) & 11'h3ff;
        frame(1'b0, ADDR_TIMING, v, 11'h000);
        mgs_spi_host_inst.xfer({1'b0, ADDR_TIMING, ~v}, 15);
        mgs_spi_host_inst.xfer({1'b0, ADDR_TIMING, ~v}, 17);
        frame(1'b1, ADDR_TIMING, 11'h000, v);
        v = (11'($urandom) & 11'h4ed) | 11'h002;
        frame(1'b0, ADDR_OPER, v, 11'h000);
        check(clears, 1);
        frame(1'b1, ADDR_OPER, 11'h000, v & 11'h7fd);
        @(negedge i_clk_sys);
        i_monitors = '1;
        frame(1'b0, ADDR_OPER, 11'h310, v & 11'h7fd);
        frame(1'b1, ADDR_OC, 11'h000, stat('1, 4'h2) & 11'h7f8);
        frame(1'b1, ADDR_CHIP, 11'h000, stat('1, 4'h3) & 11'h3ff);
        frame(1'b1, ADDR_GS, 11'h000, 11'h000);
        frame(1'b1, ADDR_HS, 11'h000, v5);
        @(negedge i_clk_sys);
        i_sleep_entry = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        check(o_config, CFG_DEFAULT);
        i_sleep_entry = 1'b0;
        frame(1'b1, ADDR_HS, 11'h000, RST_HS);
        check(exp_q.size(), 0);
        check(o_sdo_oe, 1'b0);
        close_out();
    end
endmodule
